/* rtl/plldps_pkg.sv */
// Shared constants and decode helpers for the phase-step and loop settings
package plldps_pkg;
  // Clock rate and shift-clock timing
  localparam int CLK_MHZ        = 250;
  localparam int SHIFT_HALF_NS  = 20;
  localparam int SHIFT_HALF_CYC = (SHIFT_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int SHIFT_TIME_NS  = 28;
  localparam int SHIFT_CYC      = (SHIFT_TIME_NS * CLK_MHZ + 999) / 1000;

  // Counter layout: outputs 0..4, feedback 5, prescale 6
  localparam int N_CNT   = 7;
  localparam int N_OUT   = 5;
  localparam int N_TAP   = 6;
  localparam int IDX_FB  = 5;

  // Counter pick codes
  localparam logic [2:0] PICK_ALL  = 3'h0;
  localparam logic [2:0] PICK_FB   = 3'h1;
  localparam logic [2:0] PICK_OUT0 = 3'h2;
  localparam logic [2:0] PICK_OUT4 = 3'h6;

  // Register offsets of the controller
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LOOP   = 8'h08;
  localparam logic [7:0] REG_BYPASS = 8'h0C;
  localparam logic [7:0] REG_COUNT0 = 8'h10;
  localparam logic [7:0] REG_COUNT6 = 8'h28;

  // Field positions
  localparam int CTRL_GO_BIT    = 0;
  localparam int CTRL_PICK_LSB  = 1;
  localparam int CTRL_DIR_BIT   = 4;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_ERR_BIT   = 2;
  localparam int STAT_CNT_LSB   = 8;
  localparam int LOOP_PUMP_LSB  = 0;
  localparam int LOOP_RES_LSB   = 4;
  localparam int LOOP_CAP_LSB   = 12;

  // Reset values
  localparam logic [2:0]  PUMP_RST   = 3'h0;
  localparam logic [4:0]  RES_RST    = 5'h00;
  localparam logic [1:0]  CAP_RST    = 2'h0;
  localparam logic [6:0]  BYPASS_RST = 7'h7F;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [2:0]  TAP_RST    = 3'h0;

  // Legal pump current patterns
  function automatic logic pump_legal(input logic [2:0] c);
    return c == 3'h0 || c == 3'h4 || c == 3'h6 || c == 3'h7;
  endfunction

  // Legal filter resistor settings
  function automatic logic res_legal(input logic [4:0] c);
    case (c)
      5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13,
      5'h14, 5'h18, 5'h1B, 5'h1C, 5'h1E: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Legal filter capacitor patterns
  function automatic logic cap_legal(input logic [1:0] c);
    return c != 2'h2;
  endfunction
endpackage

/* rtl/plldps_if.sv */
// Link between the phase-step controller and the PLL reconfiguration end
`timescale 1ns/1ps
interface plldps_if;
  logic                  shift_clk;
  logic                  phase_step;
  logic                  phase_dir;
  logic [2:0]            counter_pick;
  logic                  phase_done;
  logic [2:0]            pump_current_code;
  logic [4:0]            filter_resistor_code;
  logic [1:0]            filter_capacitor_code;
  logic [6:0]            counter_bypass;
  logic [6:0][15:0]      counter_count;
  logic                  pll_reset;

  // Controller end
  modport host (
    output shift_clk, phase_step, phase_dir, counter_pick,
    output pump_current_code, filter_resistor_code,
    output filter_capacitor_code, counter_bypass, counter_count,
    output pll_reset,
    input  phase_done
  );

  // PLL reconfiguration end
  modport dev (
    input  shift_clk, phase_step, phase_dir, counter_pick,
    input  pump_current_code, filter_resistor_code,
    input  filter_capacitor_code, counter_bypass, counter_count,
    input  pll_reset,
    output phase_done
  );
endinterface

/* rtl/plldps_device.sv */
// PLL reconfiguration end: loop settings, bypass and dynamic phase steps
`timescale 1ns/1ps

module plldps_device (
  input  wire logic             clk,
  input  wire logic             reset,
  plldps_if.dev                 link,
  output logic [6:0][8:0]       counter_factor,
  output logic [5:0][2:0]       phase_tap,
  output logic [4:0]            out_tick,
  output logic [2:0]            pump_active,
  output logic [4:0]            resistor_active,
  output logic [1:0]            capacitor_active,
  output logic                  loop_code_error
);

  typedef enum logic [1:0] {
    PLLDPS_IDLE,
    PLLDPS_WAIT,
    PLLDPS_SHIFT
  } plldps_dstate_t;

  plldps_dstate_t               state_q;
  logic                         sck_q;
  logic                         sck_rise;
  logic                         sck_fall;
  logic                         armed_q;
  logic                         rise_seen_q;
  logic                         done_q;
  logic                         dir_q;
  logic [2:0]                   pick_q;
  logic [7:0]                   timer_q;
  logic [6:0][8:0]              factor_q;
  logic [5:0][2:0]              tap_q;
  logic [4:0][8:0]              div_q;
  logic [4:0]                   tick_q;
  logic [2:0]                   pump_q;
  logic [4:0]                   res_q;
  logic [1:0]                   cap_q;
  logic                         err_q;

  // Does a pick code select tap t
  function automatic logic tap_hit(input logic [2:0] pick,
                                   input int          t);
    if (t == plldps_pkg::IDX_FB) begin
      return pick == plldps_pkg::PICK_FB;
    end
    return pick == plldps_pkg::PICK_ALL ||
           pick == plldps_pkg::PICK_OUT0 + 3'(t);
  endfunction

  // Shift clock comes from logic on this clock, so no synchroniser
  assign sck_rise = link.shift_clk & ~sck_q;
  assign sck_fall = ~link.shift_clk & sck_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= link.shift_clk;
    end
  end

  // Rearm only after the request was seen low, one step per pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      armed_q <= 1'b1;
    end else if (sck_fall && !link.phase_step) begin
      armed_q <= 1'b1;
    end else if (state_q == PLLDPS_IDLE && sck_fall && link.phase_step
                 && armed_q) begin
      armed_q <= 1'b0;
    end
  end

  // Phase-step sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q     <= PLLDPS_IDLE;
      rise_seen_q <= 1'b0;
      done_q      <= 1'b1;
      dir_q       <= 1'b0;
      pick_q      <= plldps_pkg::PICK_ALL;
      timer_q     <= 8'h00;
    end else begin
      case (state_q)
        PLLDPS_IDLE: begin
          // Done low never reaches here, so busy requests are dropped
          if (sck_fall && link.phase_step && armed_q) begin
            state_q     <= PLLDPS_WAIT;
            rise_seen_q <= 1'b0;
          end
        end
        PLLDPS_WAIT: begin
          if (sck_rise) begin
            if (rise_seen_q) begin
              dir_q   <= link.phase_dir;
              pick_q  <= link.counter_pick;
              done_q  <= 1'b0;
              timer_q <= 8'(plldps_pkg::SHIFT_CYC);
              state_q <= PLLDPS_SHIFT;
            end else begin
              rise_seen_q <= 1'b1;
            end
          end
        end
        PLLDPS_SHIFT: begin
          // Shift length is internal timing, not tied to the shift clock
          if (timer_q <= 8'h01) begin
            done_q  <= 1'b1;
            state_q <= PLLDPS_IDLE;
          end else begin
            timer_q <= timer_q - 8'h01;
          end
        end
        default: begin
          state_q <= PLLDPS_IDLE;
          done_q  <= 1'b1;
        end
      endcase
    end
  end

  assign link.phase_done = done_q;

  // Tap moves one eighth period at the end of the shift
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int t = 0; t < plldps_pkg::N_TAP; t++) begin
        tap_q[t] <= plldps_pkg::TAP_RST;
      end
    end else if (state_q == PLLDPS_SHIFT && timer_q <= 8'h01) begin
      for (int t = 0; t < plldps_pkg::N_TAP; t++) begin
        if (tap_hit(pick_q, t)) begin
          if (dir_q) begin
            tap_q[t] <= tap_q[t] + 3'h1;
          end else begin
            tap_q[t] <= tap_q[t] - 3'h1;
          end
        end
      end
    end
  end

  // Effective factors; a zero count is treated as one to keep ticks alive
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < plldps_pkg::N_CNT; i++) begin
        factor_q[i] <= 9'h001;
      end
    end else begin
      for (int i = 0; i < plldps_pkg::N_CNT; i++) begin
        if (link.counter_bypass[i]) begin
          factor_q[i] <= 9'h001;
        end else if (link.counter_count[i] == 16'h0000) begin
          factor_q[i] <= 9'h001;
        end else begin
          factor_q[i] <= {1'b0, link.counter_count[i][15:8]} +
                         {1'b0, link.counter_count[i][7:0]};
        end
      end
    end
  end

  // Output dividers never pause for a phase step; a relock restarts them
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < plldps_pkg::N_OUT; i++) begin
        div_q[i]  <= 9'h000;
        tick_q[i] <= 1'b0;
      end
    end else if (link.pll_reset) begin
      for (int i = 0; i < plldps_pkg::N_OUT; i++) begin
        div_q[i]  <= 9'h000;
        tick_q[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < plldps_pkg::N_OUT; i++) begin
        if (div_q[i] + 9'h001 >= factor_q[i]) begin
          div_q[i]  <= 9'h000;
          tick_q[i] <= 1'b1;
        end else begin
          div_q[i]  <= div_q[i] + 9'h001;
          tick_q[i] <= 1'b0;
        end
      end
    end
  end

  // Loop settings follow live; an illegal code keeps the last good one
  always_ff @(posedge clk) begin
    if (reset) begin
      pump_q <= plldps_pkg::PUMP_RST;
      res_q  <= plldps_pkg::RES_RST;
      cap_q  <= plldps_pkg::CAP_RST;
      err_q  <= 1'b0;
    end else begin
      if (plldps_pkg::pump_legal(link.pump_current_code)) begin
        pump_q <= link.pump_current_code;
      end
      if (plldps_pkg::res_legal(link.filter_resistor_code)) begin
        res_q <= link.filter_resistor_code;
      end
      if (plldps_pkg::cap_legal(link.filter_capacitor_code)) begin
        cap_q <= link.filter_capacitor_code;
      end
      err_q <= !plldps_pkg::pump_legal(link.pump_current_code) ||
               !plldps_pkg::res_legal(link.filter_resistor_code) ||
               !plldps_pkg::cap_legal(link.filter_capacitor_code);
    end
  end

  // User-side outputs
  assign counter_factor   = factor_q;
  assign phase_tap        = tap_q;
  assign out_tick         = tick_q;
  assign pump_active      = pump_q;
  assign resistor_active  = res_q;
  assign capacitor_active = cap_q;
  assign loop_code_error  = err_q;

endmodule

/* rtl/plldps_host.sv */
// Core-side controller: register port, shift clock and phase-step handshake
`timescale 1ns/1ps
module plldps_host (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [7:0]       addr,
  input  wire logic [31:0]      wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic [31:0]           rdata,
  plldps_if.host                link
);

  typedef enum logic [2:0] {
    PLLDPS_H_IDLE,
    PLLDPS_H_SETUP,
    PLLDPS_H_ASSERT,
    PLLDPS_H_RELEASE,
    PLLDPS_H_GAP
  } plldps_hstate_t;

  plldps_hstate_t               state_q;
  logic [7:0]                   half_q;
  logic                         sck_q;
  logic                         rise_en;
  logic                         step_q;
  logic                         dir_q;
  logic [2:0]                   pick_q;
  logic [1:0]                   hold_q;
  logic [7:0]                   steps_q;
  logic                         err_q;
  logic [2:0]                   pump_q;
  logic [4:0]                   res_q;
  logic [1:0]                   cap_q;
  logic [6:0]                   bypass_q;
  logic [6:0][15:0]             count_q;
  logic [31:0]                  rdata_q;
  logic                         go;
  logic                         loop_ok;
  logic [2:0]                   cidx;
  logic                         cnt_hit;
  logic                         done_seen_q;
  logic                         pll_rst_q;

  // Register decode
  assign go      = wr && addr == plldps_pkg::REG_CTRL &&
                   wdata[plldps_pkg::CTRL_GO_BIT];
  assign loop_ok =
    plldps_pkg::pump_legal(wdata[plldps_pkg::LOOP_PUMP_LSB +: 3]) &&
    plldps_pkg::res_legal(wdata[plldps_pkg::LOOP_RES_LSB +: 5]) &&
    plldps_pkg::cap_legal(wdata[plldps_pkg::LOOP_CAP_LSB +: 2]);
  assign cidx    = 3'((addr - plldps_pkg::REG_COUNT0) >> 2);
  assign cnt_hit = addr >= plldps_pkg::REG_COUNT0 &&
                   addr <= plldps_pkg::REG_COUNT6 && addr[1:0] == 2'h0;

  // Free-running shift clock from a divider; rise_en marks its rise
  assign rise_en = half_q == 8'h00 && !sck_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      half_q <= 8'(plldps_pkg::SHIFT_HALF_CYC - 1);
      sck_q  <= 1'b0;
    end else if (half_q == 8'h00) begin
      half_q <= 8'(plldps_pkg::SHIFT_HALF_CYC - 1);
      sck_q  <= ~sck_q;
    end else begin
      half_q <= half_q - 8'h01;
    end
  end

  // Step handshake; request changes only with a shift-clock rise
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= PLLDPS_H_IDLE;
      step_q  <= 1'b0;
      dir_q   <= 1'b0;
      pick_q  <= plldps_pkg::PICK_ALL;
      hold_q  <= 2'h0;
      done_seen_q <= 1'b0;
    end else begin
      case (state_q)
        PLLDPS_H_IDLE: begin
          if (go) begin
            dir_q   <= wdata[plldps_pkg::CTRL_DIR_BIT];
            pick_q  <= wdata[plldps_pkg::CTRL_PICK_LSB +: 3];
            state_q <= PLLDPS_H_SETUP;
          end
        end
        PLLDPS_H_SETUP: begin
          if (rise_en) begin
            step_q      <= 1'b1;
            hold_q      <= 2'h0;
            done_seen_q <= 1'b0;
            state_q     <= PLLDPS_H_ASSERT;
          end
        end
        PLLDPS_H_ASSERT: begin
          // Done may be low for less than a shift cycle, so remember it
          if (!link.phase_done) begin
            done_seen_q <= 1'b1;
          end
          if (rise_en) begin
            if (hold_q >= 2'h2 && done_seen_q) begin
              step_q  <= 1'b0;
              state_q <= PLLDPS_H_RELEASE;
            end else if (hold_q != 2'h3) begin
              hold_q <= hold_q + 2'h1;
            end
          end
        end
        PLLDPS_H_RELEASE: begin
          if (link.phase_done) begin
            state_q <= PLLDPS_H_GAP;
          end
        end
        PLLDPS_H_GAP: begin
          // Keeps pulses at least one shift cycle apart
          if (rise_en) begin
            state_q <= PLLDPS_H_IDLE;
          end
        end
        default: begin
          state_q <= PLLDPS_H_IDLE;
          step_q  <= 1'b0;
        end
      endcase
    end
  end

  // Completed steps and sticky error; a new error beats the clear
  always_ff @(posedge clk) begin
    if (reset) begin
      steps_q <= 8'h00;
      err_q   <= 1'b0;
    end else begin
      if (state_q == PLLDPS_H_RELEASE && link.phase_done) begin
        steps_q <= steps_q + 8'h01;
      end
      if (wr && addr == plldps_pkg::REG_LOOP && !loop_ok) begin
        err_q <= 1'b1;
      end else if (wr && addr == plldps_pkg::REG_STATUS &&
                   wdata[plldps_pkg::STAT_ERR_BIT]) begin
        err_q <= 1'b0;
      end
    end
  end

  // Relock pulse after loop, feedback or prescale changes; outputs need none
  always_ff @(posedge clk) begin
    if (reset) begin
      pll_rst_q <= 1'b0;
    end else begin
      pll_rst_q <= wr && ((addr == plldps_pkg::REG_LOOP && loop_ok) ||
                   (cnt_hit && cidx >= 3'(plldps_pkg::IDX_FB)) ||
                   (addr == plldps_pkg::REG_BYPASS &&
                    wdata[6:5] != bypass_q[6:5]));
    end
  end

  // Settings registers; an illegal loop write is refused whole
  always_ff @(posedge clk) begin
    if (reset) begin
      pump_q   <= plldps_pkg::PUMP_RST;
      res_q    <= plldps_pkg::RES_RST;
      cap_q    <= plldps_pkg::CAP_RST;
      bypass_q <= plldps_pkg::BYPASS_RST;
      for (int i = 0; i < plldps_pkg::N_CNT; i++) begin
        count_q[i] <= plldps_pkg::COUNT_RST;
      end
    end else if (wr) begin
      if (addr == plldps_pkg::REG_LOOP && loop_ok) begin
        pump_q <= wdata[plldps_pkg::LOOP_PUMP_LSB +: 3];
        res_q  <= wdata[plldps_pkg::LOOP_RES_LSB +: 5];
        cap_q  <= wdata[plldps_pkg::LOOP_CAP_LSB +: 2];
      end
      if (addr == plldps_pkg::REG_BYPASS) begin
        bypass_q <= wdata[6:0];
      end
      if (cnt_hit) begin
        count_q[cidx] <= wdata[15:0];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd) begin
      rdata_q <= 32'h0000_0000;
      if (addr == plldps_pkg::REG_CTRL) begin
        rdata_q[plldps_pkg::CTRL_PICK_LSB +: 3] <= pick_q;
        rdata_q[plldps_pkg::CTRL_DIR_BIT]       <= dir_q;
      end else if (addr == plldps_pkg::REG_STATUS) begin
        rdata_q[plldps_pkg::STAT_BUSY_BIT]     <= state_q != PLLDPS_H_IDLE;
        rdata_q[plldps_pkg::STAT_DONE_BIT]     <= link.phase_done;
        rdata_q[plldps_pkg::STAT_ERR_BIT]      <= err_q;
        rdata_q[plldps_pkg::STAT_CNT_LSB +: 8] <= steps_q;
      end else if (addr == plldps_pkg::REG_LOOP) begin
        rdata_q[plldps_pkg::LOOP_PUMP_LSB +: 3] <= pump_q;
        rdata_q[plldps_pkg::LOOP_RES_LSB +: 5]  <= res_q;
        rdata_q[plldps_pkg::LOOP_CAP_LSB +: 2]  <= cap_q;
      end else if (addr == plldps_pkg::REG_BYPASS) begin
        rdata_q[6:0] <= bypass_q;
      end else if (cnt_hit) begin
        rdata_q[15:0] <= count_q[cidx];
      end
    end
  end

  // Link drive
  assign rdata                      = rdata_q;
  assign link.shift_clk             = sck_q;
  assign link.phase_step            = step_q;
  assign link.phase_dir             = dir_q;
  assign link.counter_pick          = pick_q;
  assign link.pump_current_code     = pump_q;
  assign link.filter_resistor_code  = res_q;
  assign link.filter_capacitor_code = cap_q;
  assign link.counter_bypass        = bypass_q;
  assign link.counter_count         = count_q;
  assign link.pll_reset             = pll_rst_q;

endmodule

/* bench/plldps_monitor.sv */
// Protocol checker for the phase-step link
`timescale 1ns/1ps
module plldps_monitor (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       shift_clk,
  input wire logic       phase_step,
  input wire logic       phase_dir,
  input wire logic [2:0] counter_pick,
  input wire logic       phase_done,
  input wire logic [2:0] pump_current_code,
  input wire logic [4:0] filter_resistor_code,
  input wire logic [1:0] filter_capacitor_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic       seen_q;

  // Request level lengths, saturating so long idles never wrap
  always_ff @(posedge clk) begin
    if (reset) begin
      hi_q <= 8'h00;
      lo_q <= 8'h20;
    end else begin
      hi_q <= !phase_step ? 8'h00 : hi_q[5] ? hi_q : hi_q + 8'h01;
      lo_q <= phase_step ? 8'h00 : lo_q[5] ? lo_q : lo_q + 8'h01;
    end
  end

  // Remembers that done fell during the current request
  always_ff @(posedge clk) begin
    if (reset || !phase_step) begin
      seen_q <= 1'b0;
    end else if (!phase_done) begin
      seen_q <= 1'b1;
    end
  end

  AST_SHIFT_HALF: assert property ($rose(shift_clk) |->
    shift_clk [*5] ##1 !shift_clk) else $error("shift clock half period");
  AST_STEP_HOLD: assert property ($fell(phase_step) |->
    hi_q >= 8'h14) else $error("step request too short");
  AST_STEP_GAP: assert property ($rose(phase_step) |->
    lo_q >= 8'h0A) else $error("step requests too close");
  AST_DONE_LOW: assert property ($fell(phase_done) |->
    shift_clk ##0 (!phase_done) [*7] ##1 phase_done)
    else $error("done low time wrong");
  AST_DROP_AFTER_DONE: assert property ($fell(phase_step) |->
    seen_q) else $error("request dropped before done fell");
  AST_START_IDLE: assert property ($rose(phase_step) |->
    phase_done) else $error("request while done low");
  AST_DONE_WITH_STEP: assert property (!phase_done |->
    phase_step) else $error("done low without request");
  AST_SEL_STABLE: assert property (phase_step && $past(phase_step) |->
    $stable(phase_dir) && $stable(counter_pick))
    else $error("direction or pick moved");
  AST_PICK_RANGE: assert property (counter_pick <= 3'h6)
    else $error("pick out of range");
  AST_LOOP_CODES: assert property (
    pump_current_code inside {3'h0, 3'h4, 3'h6, 3'h7} &&
    filter_resistor_code inside {5'h00, 5'h03, 5'h04, 5'h08, 5'h10,
      5'h13, 5'h14, 5'h18, 5'h1B, 5'h1C, 5'h1E} &&
    filter_capacitor_code != 2'h2) else $error("illegal loop code");

  // Main scenarios
  CV_STEP: cover property ($fell(phase_done));
  CV_UP: cover property ($rose(phase_step) && phase_dir);
  CV_ALL: cover property ($rose(phase_step) && counter_pick == 3'h0);
endmodule

/* bench/plldps_tb.sv */
// Bench joining controller and reconfiguration end
`timescale 1ns/1ps
module plldps_tb;
  logic            clk;
  logic            reset;
  logic [7:0]      addr;
  logic [31:0]     wdata;
  logic            wr;
  logic            rd;
  logic [31:0]     rdata;
  logic [6:0][8:0] counter_factor;
  logic [5:0][2:0] phase_tap;
  logic [4:0]      out_tick;
  logic [2:0]      pump_active;
  logic [4:0]      resistor_active;
  logic [1:0]      capacitor_active;
  logic            loop_code_error;
  logic [31:0]     d;
  logic [2:0]      exp_tap [6];
  logic [9:0]      exp_loop;
  logic [7:0]      n_step;
  int              ticks;
  int              n_mismatch;
  int              n_tests;

  plldps_if link ();
  plldps_host plldps_host_inst (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link.host));
  plldps_device plldps_device_inst (.clk(clk), .reset(reset),
    .link(link.dev), .counter_factor(counter_factor),
    .phase_tap(phase_tap), .out_tick(out_tick),
    .pump_active(pump_active), .resistor_active(resistor_active),
    .capacitor_active(capacitor_active),
    .loop_code_error(loop_code_error));
  plldps_monitor plldps_monitor_inst (.clk(clk), .reset(reset),
    .shift_clk(link.shift_clk), .phase_step(link.phase_step),
    .phase_dir(link.phase_dir), .counter_pick(link.counter_pick),
    .phase_done(link.phase_done),
    .pump_current_code(link.pump_current_code),
    .filter_resistor_code(link.filter_resistor_code),
    .filter_capacitor_code(link.filter_capacitor_code));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Output divider 0 pulses, counted to show it runs during steps
  always @(posedge clk) begin
    if (out_tick[0] === 1'b1) ticks++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand from the cycle after the strobe until the next read
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Illegal words are refused whole and flag the error bit
  task automatic try_loop(input logic [2:0] p, input logic [4:0] r,
                          input logic [1:0] c);
    logic ok;
    ok = p inside {3'h0, 3'h4, 3'h6, 3'h7} && c != 2'h2 &&
      r inside {5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13, 5'h14,
      5'h18, 5'h1B, 5'h1C, 5'h1E};
    wr_reg(plldps_pkg::REG_LOOP, {18'h0, c, 3'h0, r, 1'b0, p});
    if (ok) exp_loop = {p, r, c};
    repeat (3) @(posedge clk);
    chk(32'({pump_active, resistor_active, capacitor_active}),
        32'(exp_loop));
    chk(32'({link.pump_current_code, link.filter_resistor_code,
        link.filter_capacitor_code}), 32'(exp_loop));
    chk(32'(loop_code_error), 32'h0000_0000);
    rd_reg(plldps_pkg::REG_STATUS);
    chk(32'(d[2]), 32'(!ok));
    wr_reg(plldps_pkg::REG_STATUS, 32'h0000_0004);
  endtask

  // Go is written twice; the second lands while busy and is dropped
  task automatic do_step(input logic [2:0] p, input logic dr);
    int k;
    k = 0;
    wr_reg(plldps_pkg::REG_CTRL, {27'h0, dr, p, 1'b1});
    wr_reg(plldps_pkg::REG_CTRL, {27'h0, dr, p, 1'b1});
    d = 32'h0000_0001;
    while (d[0] !== 1'b0 && k < 100) begin
      rd_reg(plldps_pkg::REG_STATUS);
      k++;
    end
    n_step++;
    for (int i = 0; i < 6; i++) begin
      if (p == 3'h0 ? i < 5 : p == 3'h1 ? i == 5 : i == p - 2)
        exp_tap[i] = dr ? exp_tap[i] + 3'h1 : exp_tap[i] - 3'h1;
    end
    chk(d & 32'h0000_FF07, {16'h0, n_step, 8'h02});
    for (int i = 0; i < 6; i++) begin
      chk(32'(phase_tap[i]), 32'(exp_tap[i]));
    end
  endtask

  // Hang guard, well beyond the twelve hundred or so cycles of the run
  initial begin
    #100000;
    n_mismatch++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    reset = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    ticks = 0;
    n_step = 8'h00;
    exp_loop = 10'h000;
    foreach (exp_tap[i]) exp_tap[i] = 3'h0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd_reg(plldps_pkg::REG_STATUS);
    chk(d & 32'h0000_0003, 32'h0000_0002);
    rd_reg(plldps_pkg::REG_BYPASS);
    chk(d, 32'h0000_007F);
    for (int i = 0; i < 7; i++) begin
      chk(32'(counter_factor[i]), 32'h0000_0001);
    end
    wr_reg(8'hF0, 32'hFFFF_FFFF);
    rd_reg(8'hF0);
    chk(d, 32'h0000_0000);
    $display("Test reset state done");
    for (int i = 0; i < 8; i++) try_loop(3'(i), 5'h00, 2'h0);
    for (int i = 0; i < 32; i++) try_loop(3'h7, 5'(i), 2'h1);
    for (int i = 0; i < 4; i++) try_loop(3'h4, 5'h13, 2'(i));
    $display("Test loop codes done");
    wr_reg(plldps_pkg::REG_COUNT0, 32'h0000_0305);
    wr_reg(8'h24, 32'h0000_0102);
    repeat (2) @(posedge clk);
    chk(32'(counter_factor[0]), 32'h0000_0001);
    wr_reg(plldps_pkg::REG_BYPASS, 32'h0000_005E);
    repeat (2) @(posedge clk);
    chk(32'(counter_factor[0]), 32'h0000_0008);
    chk(32'(counter_factor[5]), 32'h0000_0003);
    chk(32'(counter_factor[6]), 32'h0000_0001);
    @(posedge clk);
    chk(32'(out_tick[4:1]), 32'h0000_000F);
    $display("Test bypass done");
    fork
      do_step(3'h0, 1'b1);
      begin
        repeat (4) @(posedge clk);
        k_ticks();
      end
    join
    for (int p = 0; p < 7; p++) begin
      do_step(3'(p), 1'b0);
      do_step(3'(p), 1'b1);
    end
    $display("Test phase steps done");
    stop_test();
  end

  // Ticks over 80 cycles at divide by 8 during a step
  task automatic k_ticks;
    int t0;
    // Read off the edge so the tick counter has settled
    #1 t0 = ticks;
    repeat (80) @(posedge clk);
    #1 chk(32'(ticks - t0), 32'h0000_000A);
  endtask
endmodule
